// file: rtl/bdbc_pkg.sv
package bdbc_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CONTROL  = 8'h00;
    localparam logic [7:0] OFS_RISE_CNT = 8'h04;
    localparam logic [7:0] OFS_FALL_CNT = 8'h08;
    localparam logic [7:0] OFS_STATUS   = 8'h0c;

    // ------------------------------------------------------------
    // Control field positions
    // ------------------------------------------------------------
    localparam int CTL_EN_BIT   = 0;
    localparam int CTL_FULL_BIT = 1;
    localparam int CTL_DIR_BIT  = 2;
    localparam int CTL_LD_BIT   = 3;

    // ------------------------------------------------------------
    // Widths and reset values
    // ------------------------------------------------------------
    localparam int         DB_WIDTH     = 6;
    localparam logic [5:0] DB_RESET_VAL = 6'h00;

    localparam logic [1:0] AXI_OKAY   = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;

    // ------------------------------------------------------------
    // Output group
    // ------------------------------------------------------------
    typedef struct packed {
        logic first;
        logic second;
        logic third;
        logic fourth;
    } bdbc_drive_s;

    typedef struct packed {
        logic en;
        logic full;
        logic dir;
    } bdbc_ctrl_s;

endpackage

// file: rtl/bdbc_delay.sv
`timescale 1ns/1ps

// ------------------------------------------------------------
// Dead-band delay counter
// ------------------------------------------------------------
module bdbc_delay
    import bdbc_pkg::*;
#(
    parameter int W = DB_WIDTH
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // Request and count
    input  wire logic         req,
    input  wire logic [W-1:0] count,
    // Delayed level
    output logic              out
);

    logic [W-1:0] cnt_q;

    // Count from zero while request holds; drop on loss of request
    always_ff @(posedge clk) begin
        if (rst || !req) begin
            cnt_q <= '0;
        end else if (cnt_q != count) begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    // Short request never completes, no pulse
    always_ff @(posedge clk) begin
        if (rst || !req) begin
            out <= 1'b0;
        end else begin
            out <= (cnt_q == count);
        end
    end

endmodule

// file: rtl/bdbc_top.sv
// Summary of operation
// - Two independent six-bit dead-band counters: rising/reverse and falling/forward.
// - Rising counter delays rising input edges (half), reverse direction (full).
// - Falling counter delays falling input edges (half), forward direction (full).
// - Dead band counts clock periods from zero up to the count value.
// - Half bridge: inverted output waits the dead band after normal falls.
// - Full bridge: direction bit may toggle while running, switching direction.
// - After direction change A and C switch at rising edge; B/D delayed.
// - Rising count delays leading edge of A (half), or of B (full) only after a direction change; otherwise B follows the input.
// - Falling count delays leading edge of B (half), or of D (full) only after a direction change; otherwise D follows the input.
// - Counts double-buffered; while disabled a write loads the working count at once.
// - While enabled, load request moves buffers at next input falling edge.
// - Input shorter than the dead band gives no pulse on that output in half mode or after a direction change.
`timescale 1ns/1ps

module bdbc_top
    import bdbc_pkg::*;
(
    // Clock and reset
    input  wire logic        CLK,
    input  wire logic        RST,
    // Input source pin
    input  wire logic        SRC_IN,
    // Bridge drives
    output bdbc_drive_s      DRIVE_OUT,
    // AXI4-Lite write address
    input  wire logic [7:0]  S_AWADDR,
    input  wire logic        S_AWVALID,
    output logic             S_AWREADY,
    // AXI4-Lite write data
    input  wire logic [31:0] S_WDATA,
    input  wire logic [3:0]  S_WSTRB,
    input  wire logic        S_WVALID,
    output logic             S_WREADY,
    // AXI4-Lite write response
    output logic [1:0]       S_BRESP,
    output logic             S_BVALID,
    input  wire logic        S_BREADY,
    // AXI4-Lite read address
    input  wire logic [7:0]  S_ARADDR,
    input  wire logic        S_ARVALID,
    output logic             S_ARREADY,
    // AXI4-Lite read data
    output logic [31:0]      S_RDATA,
    output logic [1:0]       S_RRESP,
    output logic             S_RVALID,
    input  wire logic        S_RREADY
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic                src_m_q;
    logic                src_q;
    logic                src_d1_q;
    logic                src_rise;
    logic                src_fall;
    bdbc_ctrl_s          ctrl_q;
    logic                ld_req_q;
    logic [DB_WIDTH-1:0] rise_buf_q;
    logic [DB_WIDTH-1:0] fall_buf_q;
    logic [DB_WIDTH-1:0] rise_work_q;
    logic [DB_WIDTH-1:0] fall_work_q;
    logic                dir_q;
    logic                dir_pend_q;
    logic                rise_req;
    logic                fall_req;
    logic                rise_done;
    logic                fall_done;
    logic                aw_q;
    logic                w_q;
    logic [7:0]          awaddr_q;
    logic [31:0]         wdata_q;
    logic [3:0]          wstrb_q;
    logic                wr_go;
    logic                wr_ok;
    logic                ld_xfer;
    bdbc_drive_s         drive_d;
    logic                wr_ctrl;
    logic                wr_rise;
    logic                wr_fall;
    logic [31:0]         rdata_d;
    logic [1:0]          rresp_d;

    // ------------------------------------------------------------
    // Input synchroniser and edges
    // ------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (RST) begin
            src_m_q  <= 1'b0;
            src_q    <= 1'b0;
            src_d1_q <= 1'b0;
        end else begin
            src_m_q  <= SRC_IN;
            src_q    <= src_m_q;
            src_d1_q <= src_q;
        end
    end

    assign src_rise = src_q && !src_d1_q;
    assign src_fall = !src_q && src_d1_q;

    // ------------------------------------------------------------
    // AXI4-Lite write path
    // ------------------------------------------------------------
    assign S_AWREADY = !aw_q && !S_BVALID;
    assign S_WREADY  = !w_q && !S_BVALID;
    assign wr_go     = aw_q && w_q && !S_BVALID;
    assign wr_ok     = (awaddr_q[1:0] == 2'h0) && (awaddr_q <= OFS_STATUS);

    // ------------------------------------------------------------
    // Register write strobes
    // ------------------------------------------------------------
    assign wr_ctrl = wr_go && wstrb_q[0] && (awaddr_q == OFS_CONTROL);
    assign wr_rise = wr_go && wstrb_q[0] && (awaddr_q == OFS_RISE_CNT);
    assign wr_fall = wr_go && wstrb_q[0] && (awaddr_q == OFS_FALL_CNT);

    always_ff @(posedge CLK) begin
        if (RST) begin
            aw_q     <= 1'b0;
            awaddr_q <= 8'h00;
        end else if (S_AWVALID && S_AWREADY) begin
            aw_q     <= 1'b1;
            awaddr_q <= S_AWADDR;
        end else if (wr_go) begin
            aw_q     <= 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            w_q     <= 1'b0;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
        end else if (S_WVALID && S_WREADY) begin
            w_q     <= 1'b1;
            wdata_q <= S_WDATA;
            wstrb_q <= S_WSTRB;
        end else if (wr_go) begin
            w_q     <= 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            S_BVALID <= 1'b0;
            S_BRESP  <= AXI_OKAY;
        end else if (wr_go) begin
            S_BVALID <= 1'b1;
            S_BRESP  <= wr_ok ? AXI_OKAY : AXI_SLVERR;
        end else if (S_BREADY) begin
            S_BVALID <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (RST) begin
            ctrl_q <= '0;
        end else if (wr_ctrl) begin
            ctrl_q.en   <= wdata_q[CTL_EN_BIT];
            ctrl_q.full <= wdata_q[CTL_FULL_BIT];
            ctrl_q.dir  <= wdata_q[CTL_DIR_BIT];
        end
    end

    // Load request: set by software, cleared by transfer or while disabled, set wins
    assign ld_xfer = ld_req_q && ctrl_q.en && src_fall;

    always_ff @(posedge CLK) begin
        if (RST) begin
            ld_req_q <= 1'b0;
        end else if (wr_ctrl && wdata_q[CTL_LD_BIT]) begin
            ld_req_q <= 1'b1;
        end else if (ld_xfer || !ctrl_q.en) begin
            ld_req_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Double-buffered counts
    // ------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (RST) begin
            rise_buf_q <= DB_RESET_VAL;
        end else if (wr_rise) begin
            rise_buf_q <= wdata_q[DB_WIDTH-1:0];
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            fall_buf_q <= DB_RESET_VAL;
        end else if (wr_fall) begin
            fall_buf_q <= wdata_q[DB_WIDTH-1:0];
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            rise_work_q <= DB_RESET_VAL;
            fall_work_q <= DB_RESET_VAL;
        end else if (!ctrl_q.en) begin
            rise_work_q <= rise_buf_q;
            fall_work_q <= fall_buf_q;
        end else if (ld_xfer) begin
            rise_work_q <= rise_buf_q;
            fall_work_q <= fall_buf_q;
        end
    end

    // ------------------------------------------------------------
    // Direction tracking, applied at rising input edge
    // ------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (RST) begin
            dir_q      <= 1'b0;
            dir_pend_q <= 1'b0;
        end else if (!ctrl_q.en) begin
            dir_q      <= ctrl_q.dir;
            dir_pend_q <= 1'b0;
        end else if (src_rise && dir_q != ctrl_q.dir) begin
            dir_q      <= ctrl_q.dir;
            dir_pend_q <= 1'b1;
        end else if (!src_q) begin
            dir_pend_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Dead-band counters
    // ------------------------------------------------------------
    // Half: rise timer on high input, fall timer on low input.
    // Full: reverse (dir=1) uses rise timer, forward uses fall timer.
    always_comb begin
        if (ctrl_q.full) begin
            rise_req = ctrl_q.en && src_q && dir_q;
            fall_req = ctrl_q.en && src_q && !dir_q;
        end else begin
            rise_req = ctrl_q.en && src_q;
            fall_req = ctrl_q.en && !src_q;
        end
    end

    bdbc_delay #(.W(DB_WIDTH)) u_rise (
        .clk   (CLK),
        .rst   (RST),
        .req   (rise_req),
        .count (rise_work_q),
        .out   (rise_done)
    );

    bdbc_delay #(.W(DB_WIDTH)) u_fall (
        .clk   (CLK),
        .rst   (RST),
        .req   (fall_req),
        .count (fall_work_q),
        .out   (fall_done)
    );

    // ------------------------------------------------------------
    // Output steering
    // ------------------------------------------------------------
    always_comb begin
        drive_d = '0;
        if (ctrl_q.en) begin
            if (!ctrl_q.full) begin
                drive_d.first  = rise_done;
                drive_d.second = fall_done;
                drive_d.third  = rise_done;
                drive_d.fourth = fall_done;
            end else if (!dir_q) begin
                // Forward: A on, D modulated
                drive_d.first  = 1'b1;
                drive_d.fourth = dir_pend_q ? fall_done : (fall_done || src_q);
            end else begin
                // Reverse: C on, B modulated
                drive_d.third  = 1'b1;
                drive_d.second = dir_pend_q ? rise_done : (rise_done || src_q);
            end
        end
    end

    // ------------------------------------------------------------
    // Output register
    // ------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (RST) begin
            DRIVE_OUT <= '0;
        end else begin
            DRIVE_OUT <= drive_d;
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite read path
    // ------------------------------------------------------------
    assign S_ARREADY = !S_RVALID;

    // ------------------------------------------------------------
    // Read mux, unused bits read zero
    // ------------------------------------------------------------
    always_comb begin
        rdata_d = 32'h0000_0000;
        rresp_d = AXI_OKAY;
        unique case (S_ARADDR)
            OFS_CONTROL: begin
                rdata_d[CTL_EN_BIT]   = ctrl_q.en;
                rdata_d[CTL_FULL_BIT] = ctrl_q.full;
                rdata_d[CTL_DIR_BIT]  = ctrl_q.dir;
                rdata_d[CTL_LD_BIT]   = ld_req_q;
            end
            OFS_RISE_CNT: rdata_d[DB_WIDTH-1:0] = rise_buf_q;
            OFS_FALL_CNT: rdata_d[DB_WIDTH-1:0] = fall_buf_q;
            OFS_STATUS: begin
                rdata_d[3:0] = {dir_q, src_q, fall_done, rise_done};
            end
            default: rresp_d = AXI_SLVERR;
        endcase
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            S_RVALID <= 1'b0;
        end else if (S_ARVALID && S_ARREADY) begin
            S_RVALID <= 1'b1;
        end else if (S_RREADY) begin
            S_RVALID <= 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            S_RDATA <= 32'h0000_0000;
            S_RRESP <= AXI_OKAY;
        end else if (S_ARVALID && S_ARREADY) begin
            S_RDATA <= rdata_d;
            S_RRESP <= rresp_d;
        end
    end

endmodule

// file: bench/bdbc_props.sv
`timescale 1ns/1ps

module bdbc_props
    import bdbc_pkg::*;
(
    // Clock and reset
    input  wire logic        CLK,
    input  wire logic        RST,
    // Bridge drives
    input  bdbc_drive_s      DRIVE_OUT,
    // Bus handshakes
    input  wire logic        S_AWVALID,
    input  wire logic        S_AWREADY,
    input  wire logic        S_WVALID,
    input  wire logic        S_WREADY,
    input  wire logic        S_BVALID,
    input  wire logic        S_ARVALID,
    input  wire logic        S_ARREADY,
    input  wire logic [31:0] S_RDATA,
    input  wire logic        S_RVALID,
    input  wire logic        S_RREADY
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RST);

    sequence s_wr_taken;
        S_AWVALID && S_AWREADY && S_WVALID && S_WREADY;
    endsequence

    a_write_resp: assert property (s_wr_taken |-> ##[1:2] S_BVALID)
        else $error("write response missing");
    a_read_resp: assert property (S_ARVALID && S_ARREADY |=> S_RVALID)
        else $error("read response missing");
    a_rdata_hold: assert property (S_RVALID && !S_RREADY |=> S_RVALID && $stable(S_RDATA))
        else $error("read data dropped");
    a_ar_refuse: assert property (S_RVALID |-> !S_ARREADY)
        else $error("read address taken during response");
    a_aw_refuse: assert property (S_BVALID |-> !S_AWREADY && !S_WREADY)
        else $error("write taken during response");
    a_leg_ab_safe: assert property (!(DRIVE_OUT.first && DRIVE_OUT.second))
        else $error("first and second on together");
    a_leg_cd_safe: assert property (!(DRIVE_OUT.third && DRIVE_OUT.fourth))
        else $error("third and fourth on together");
    a_reset_quiet: assert property ($fell(RST) |-> DRIVE_OUT == 4'h0)
        else $error("drives active after reset");
endmodule

bind bdbc_top bdbc_props i_bdbc_props (.CLK(CLK), .RST(RST), .DRIVE_OUT(DRIVE_OUT),
    .S_AWVALID(S_AWVALID), .S_AWREADY(S_AWREADY), .S_WVALID(S_WVALID),
    .S_WREADY(S_WREADY), .S_BVALID(S_BVALID), .S_ARVALID(S_ARVALID),
    .S_ARREADY(S_ARREADY), .S_RDATA(S_RDATA), .S_RVALID(S_RVALID), .S_RREADY(S_RREADY));

// file: bench/bdbc_bridge_model.sv
`timescale 1ns/1ps

module bdbc_bridge_model
    import bdbc_pkg::*;
(
    // Clock
    input  wire logic clk,
    // Gate drives
    input  bdbc_drive_s gate,
    // Observed events
    output int          n_shoot,
    output int          n_rise_a
);
    logic prev_a   = 1'b0;
    int   shoot_q  = 0;
    int   rise_a_q = 0;

    assign n_shoot  = shoot_q;
    assign n_rise_a = rise_a_q;

    // Leg shorts and pulses on the first switch
    always @(posedge clk) begin
        if ((gate.first && gate.second) || (gate.third && gate.fourth)) begin
            shoot_q <= shoot_q + 1;
        end
        if (gate.first && !prev_a) begin
            rise_a_q <= rise_a_q + 1;
        end
        prev_a <= gate.first;
    end
endmodule

// file: bench/tb.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin n_mismatch++; \
    $display("ERROR %s expected %0h seen %0h", nm, ex, got); end end

module tb;
    import bdbc_pkg::*;

    logic        CLK = 0, RST = 1, SRC_IN = 0;
    logic [7:0]  S_AWADDR = 0, S_ARADDR = 0;
    logic [31:0] S_WDATA = 0, S_RDATA;
    logic        S_AWVALID = 0, S_WVALID = 0, S_BREADY = 0, S_ARVALID = 0, S_RREADY = 0;
    logic        S_AWREADY, S_WREADY, S_BVALID, S_ARREADY, S_RVALID;
    logic [1:0]  S_BRESP, S_RRESP;
    logic [3:0]  S_WSTRB = 4'hf;
    bdbc_drive_s DRIVE_OUT;
    wire  [3:0]  drv = DRIVE_OUT;
    int          comparisons = 0, n_mismatch = 0, n_shoot, n_rise_a;

    always #10 CLK = ~CLK;

    bdbc_top i_bdbc_top (.CLK(CLK), .RST(RST), .SRC_IN(SRC_IN), .DRIVE_OUT(DRIVE_OUT),
        .S_AWADDR(S_AWADDR), .S_AWVALID(S_AWVALID), .S_AWREADY(S_AWREADY),
        .S_WDATA(S_WDATA), .S_WSTRB(S_WSTRB), .S_WVALID(S_WVALID), .S_WREADY(S_WREADY),
        .S_BRESP(S_BRESP), .S_BVALID(S_BVALID), .S_BREADY(S_BREADY),
        .S_ARADDR(S_ARADDR), .S_ARVALID(S_ARVALID), .S_ARREADY(S_ARREADY),
        .S_RDATA(S_RDATA), .S_RRESP(S_RRESP), .S_RVALID(S_RVALID), .S_RREADY(S_RREADY));

    bdbc_bridge_model i_bdbc_bridge_model (.clk(CLK), .gate(DRIVE_OUT),
        .n_shoot(n_shoot), .n_rise_a(n_rise_a));

    // ------------------------------------------------------------
    // Bus and source tasks
    // ------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge CLK);
        S_AWADDR <= a;
        S_WDATA <= d;
        S_AWVALID <= 1'b1;
        S_WVALID <= 1'b1;
        S_BREADY <= 1'b1;
        forever begin
            @(posedge CLK);
            if (S_AWVALID && S_AWREADY) S_AWVALID <= 1'b0;
            if (S_WVALID && S_WREADY) S_WVALID <= 1'b0;
            if (S_BVALID) break;
        end
        `CHK("bresp", er, S_BRESP)
        S_BREADY <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
        @(posedge CLK);
        S_ARADDR <= a;
        S_ARVALID <= 1'b1;
        forever begin
            @(posedge CLK);
            if (S_ARVALID && S_ARREADY) S_ARVALID <= 1'b0;
            if (S_RVALID && S_RREADY) break;
            if (S_RVALID) S_RREADY <= 1'b1;
        end
        d = S_RDATA;
        `CHK("rresp", er, S_RRESP)
        S_RREADY <= 1'b0;
    endtask

    task automatic lat(input logic lvl, input int b, output int n);
        @(posedge CLK);
        SRC_IN <= lvl;
        n = 0;
        do begin
            @(posedge CLK);
            n++;
        end while (drv[b] !== 1'b1 && n < 200);
    endtask

    task automatic conclude;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        logic [31:0] d;
        int          la, lb, la2, lb2, lc, k;
        repeat (8) @(posedge CLK);
        RST <= 1'b0;
        rd(OFS_CONTROL, d, AXI_OKAY);
        `CHK("control reset", 32'h0, d)
        rd(8'h10, d, AXI_SLVERR);
        wr(8'h10, 32'h1, AXI_SLVERR);
        wr(OFS_RISE_CNT, 32'h2, AXI_OKAY);
        wr(OFS_FALL_CNT, 32'h2, AXI_OKAY);
        rd(OFS_RISE_CNT, d, AXI_OKAY);
        `CHK("rise count", 32'h2, d)
        S_WSTRB <= 4'h0;
        wr(OFS_RISE_CNT, 32'h3f, AXI_OKAY);
        S_WSTRB <= 4'hf;
        rd(OFS_RISE_CNT, d, AXI_OKAY);
        `CHK("masked write", 32'h2, d)
        wr(OFS_CONTROL, 32'h1, AXI_OKAY);
        lat(1'b1, 3, la2);
        `CHK("third with first", 1'b1, drv[1])
        lat(1'b0, 2, lb2);
        `CHK("fourth with second", 1'b1, drv[0])
        wr(OFS_CONTROL, 32'h0, AXI_OKAY);
        wr(OFS_RISE_CNT, 32'h0a, AXI_OKAY);
        wr(OFS_FALL_CNT, 32'h05, AXI_OKAY);
        wr(OFS_CONTROL, 32'h1, AXI_OKAY);
        lat(1'b1, 3, la);
        `CHK("rise delay step", 8, la - la2)
        lat(1'b0, 2, lb);
        `CHK("fall delay step", 3, lb - lb2)
        // Short source pulse
        k = n_rise_a;
        @(posedge CLK);
        SRC_IN <= 1'b1;
        repeat (4) @(posedge CLK);
        SRC_IN <= 1'b0;
        repeat (30) @(posedge CLK);
        `CHK("short pulse", k, n_rise_a)
        // Buffered load while enabled
        wr(OFS_RISE_CNT, 32'h03, AXI_OKAY);
        wr(OFS_CONTROL, 32'h9, AXI_OKAY);
        rd(OFS_CONTROL, d, AXI_OKAY);
        `CHK("load pending", 1'b1, d[3])
        lat(1'b1, 3, la);
        `CHK("old count kept", la2 + 8, la)
        lat(1'b0, 2, lb);
        rd(OFS_CONTROL, d, AXI_OKAY);
        `CHK("load cleared", 1'b0, d[3])
        lat(1'b1, 3, la);
        `CHK("new count", la2 + 1, la)
        // Full bridge direction change
        lat(1'b0, 2, lb);
        wr(OFS_CONTROL, 32'h3, AXI_OKAY);
        lat(1'b1, 3, la);
        `CHK("forward first", 1'b1, drv[3])
        @(posedge CLK);
        SRC_IN <= 1'b0;
        wr(OFS_CONTROL, 32'h7, AXI_OKAY);
        @(posedge CLK);
        SRC_IN <= 1'b1;
        lc = 0;
        lb = 0;
        for (k = 1; k < 40; k++) begin
            @(posedge CLK);
            if (drv[1] === 1'b1 && lc == 0) lc = k;
            if (drv[2] === 1'b1 && lb == 0) lb = k;
        end
        `CHK("second after third", 1'b1, lc > 0 && lb - lc > 2)
        `CHK("first off", 1'b0, drv[3])
        rd(OFS_STATUS, d, AXI_OKAY);
        `CHK("applied direction", 1'b1, d[3])
        `CHK("leg shorts", 0, n_shoot)
        conclude();
    end

    initial begin
        #400000;
        n_mismatch++;
        conclude();
    end
endmodule
